// ===== core/rtc_core.sv
// Design decisions made here: register access over APB and the register addresses.
module rtc_core (
  input wire logic pclk, // Processor clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic [rtc_pkg::RTC_PADDR_W-1:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire rtc_pkg::rtc_strobe_t strobe, // Sequencer strobes
  input wire logic [rtc_pkg::RTC_BUS_W-1:0] src_bus_in, // External sources
  input wire logic [rtc_pkg::RTC_POS_W-1:0] char_pos, // Position counter
  output logic [rtc_pkg::RTC_BUS_W-1:0] src_bus_out, // Resolved bus
  output rtc_pkg::rtc_decode_t decode // Count decodes
);
  import rtc_pkg::*;

  typedef struct packed {
    logic [RTC_DIGIT_W-1:0] hub;
    logic [RTC_ZONE_W-1:0] zone;
    logic [RTC_ADDR_W-1:0] addr_one;
    logic [RTC_ADDR_W-1:0] addr_two;
    logic [RTC_ADDR_W-1:0] prog;
    logic [RTC_DIGIT_W-1:0] data;
    logic [RTC_DIGIT_W-1:0] hold;
    logic [RTC_DIGIT_W-1:0] aux_one;
    logic [RTC_DIGIT_W-1:0] aux_two;
    logic [RTC_DIGIT_W-1:0] len_one;
    logic [RTC_DIGIT_W-1:0] len_two;
    logic [RTC_DIGIT_W-1:0] func;
    logic idx_a;
    logic idx_b;
    logic flag_zero;
    logic flag_minus;
    logic flag_carry;
    logic ext_one;
    logic ext_two;
    logic dec_two_prev;
    logic inc_two_prev;
    logic dec_len_prev;
    logic [RTC_BUS_W-1:0] panel_val;
    logic panel_hub;
    logic panel_zone;
    logic [31:0] rdata;
  } rtc_state_t;

  rtc_state_t state_reg;
  rtc_state_t state_next;
  logic dec_two_evt;
  logic inc_two_evt;
  logic dec_len_evt;
  logic hub_load;
  logic zone_load;
  logic mapped;
  logic [31:0] read_word;
  logic setup_read;
  logic access_phase;
  logic zone_upper;

  // Replace one digit of an address at the position given
  function automatic logic [RTC_ADDR_W-1:0] put_digit(
    input logic [RTC_ADDR_W-1:0] word,
    input logic [RTC_POS_W-1:0] pos,
    input logic [RTC_DIGIT_W-1:0] dig
  );
    logic [RTC_ADDR_W-1:0] res;
    res = word;
    res[pos*RTC_DIGIT_W +: RTC_DIGIT_W] = dig;
    return res;
  endfunction

  // Register offsets that answer without error
  function automatic logic is_mapped(input logic [RTC_PADDR_W-1:0] a);
    return (a == RTC_OFS_PANEL) || (a == RTC_OFS_HUBZONE) ||
           (a == RTC_OFS_ADDR) || (a == RTC_OFS_PROG) ||
           (a == RTC_OFS_COUNT) || (a == RTC_OFS_FLAGS);
  endfunction

  // A strobe high at the last edge and low now has just ended
  function automatic logic trailing(
    input logic was_high,
    input logic now_high
  );
    return was_high & ~now_high;
  endfunction

  // One count step; the four-bit counters wrap rather than saturate
  function automatic logic [RTC_DIGIT_W-1:0] count_step(
    input logic [RTC_DIGIT_W-1:0] value,
    input logic up
  );
    logic [RTC_DIGIT_W-1:0] res;
    if (up) begin
      res = value + RTC_STEP;
    end else begin
      res = value - RTC_STEP;
    end
    return res;
  endfunction

  // Compare a length count against one decoded value
  function automatic logic len_is(
    input logic [RTC_DIGIT_W-1:0] value,
    input logic [RTC_DIGIT_W-1:0] match
  );
    return value == match;
  endfunction

  // Trailing edges of the count strobes become one-cycle events; the
  // history flops clear in reset, so a strobe that ends within reset is no edge
  assign dec_two_evt = trailing(state_reg.dec_two_prev,
                                strobe.aux_two_decrement);
  assign inc_two_evt = trailing(state_reg.inc_two_prev,
                                strobe.aux_two_increment);
  assign dec_len_evt = trailing(state_reg.dec_len_prev,
                                strobe.length_one_decrement);

  // Bus resolution; aux gates win since they bypass the load strobe.
  // Zone lines read zero while a counter is gated onto the bus.
  always_comb begin
    if (strobe.aux_one_to_bus) begin
      src_bus_out = {{RTC_ZONE_W{1'b0}}, state_reg.aux_one};
    end else if (strobe.aux_two_to_bus) begin
      src_bus_out = {{RTC_ZONE_W{1'b0}}, state_reg.aux_two};
    end else if (state_reg.panel_hub || state_reg.panel_zone) begin
      src_bus_out = state_reg.panel_val;
    end else begin
      src_bus_out = src_bus_in;
    end
  end

  // Hub and zone load conditions, panel acting as the test panel
  assign hub_load = strobe.load_hub | strobe.aux_one_to_bus |
                    strobe.aux_two_to_bus | state_reg.panel_hub;
  assign zone_load = strobe.load_zone | state_reg.panel_zone;

  // Upper zone flop feeds conditions, extension, function and index bits
  assign zone_upper = state_reg.zone[RTC_ZONE_HIGH];

  // APB phase decodes shared by the read latch, panel write and error
  assign setup_read = psel & ~penable & ~pwrite;
  assign access_phase = psel & penable;

  // Count decodes straight off the length and aux flops
  always_comb begin
    decode.length_one_is_zero = len_is(state_reg.len_one,
                                       RTC_LEN_ZERO);
    decode.length_one_is_one = len_is(state_reg.len_one,
                                      RTC_LEN_ONE);
    decode.length_one_is_six = len_is(state_reg.len_one,
                                      RTC_LEN_SIX);
    decode.length_one_is_seven = len_is(state_reg.len_one,
                                        RTC_LEN_SEVEN);
    decode.aux_one_low_bit = state_reg.aux_one[RTC_RW_BIT];
    decode.aux_two_low_bit = state_reg.aux_two[RTC_RW_BIT];
    decode.nonfill_read_terminate = strobe.terminate_read &
                                    state_reg.aux_one[RTC_NONFILL_BIT];
  end

  // Register read image
  assign mapped = is_mapped(paddr);
  always_comb begin
    read_word = '0;
    unique case (paddr)
      RTC_OFS_PANEL: begin
        read_word[RTC_BUS_W-1:0] = state_reg.panel_val;
      end
      RTC_OFS_HUBZONE: begin
        read_word[RTC_DIGIT_W-1:0] = state_reg.hub;
        read_word[RTC_ZONE_LSB +: RTC_ZONE_W] = state_reg.zone;
      end
      RTC_OFS_ADDR: begin
        read_word[RTC_ADDR_W-1:0] = state_reg.addr_one;
        read_word[RTC_ADDR_W +: RTC_ADDR_W] = state_reg.addr_two;
      end
      RTC_OFS_PROG: begin
        read_word[RTC_ADDR_W-1:0] = state_reg.prog;
      end
      RTC_OFS_COUNT: begin
        read_word[RTC_CNT_DATA +: RTC_DIGIT_W] = state_reg.data;
        read_word[RTC_CNT_HOLD +: RTC_DIGIT_W] = state_reg.hold;
        read_word[RTC_CNT_AUX_ONE +: RTC_DIGIT_W] = state_reg.aux_one;
        read_word[RTC_CNT_AUX_TWO +: RTC_DIGIT_W] = state_reg.aux_two;
        read_word[RTC_CNT_LEN_ONE +: RTC_DIGIT_W] = state_reg.len_one;
        read_word[RTC_CNT_LEN_TWO +: RTC_DIGIT_W] = state_reg.len_two;
      end
      RTC_OFS_FLAGS: begin
        read_word[RTC_FLG_ZERO] = state_reg.flag_zero;
        read_word[RTC_FLG_MINUS] = state_reg.flag_minus;
        read_word[RTC_FLG_CARRY] = state_reg.flag_carry;
        read_word[RTC_FLG_EXT_ONE] = state_reg.ext_one;
        read_word[RTC_FLG_EXT_TWO] = state_reg.ext_two;
        read_word[RTC_FLG_IDX_A] = state_reg.idx_a;
        read_word[RTC_FLG_IDX_B] = state_reg.idx_b;
        read_word[RTC_FLG_FUNC +: RTC_DIGIT_W] = state_reg.func;
      end
      default: begin
        read_word = '0;
      end
    endcase
  end

  // Zero wait state slave; unmapped offsets answer with an error.
  // Writes to read-only words are dropped quietly, so a map sweep is clean.
  assign pready = 1'b1;
  assign pslverr = access_phase & ~mapped;
  assign prdata = state_reg.rdata;

  // Next state of every register of the block
  always_comb begin
    state_next = state_reg;
    state_next.dec_two_prev = strobe.aux_two_decrement;
    state_next.inc_two_prev = strobe.aux_two_increment;
    state_next.dec_len_prev = strobe.length_one_decrement;
    state_next.panel_hub = 1'b0;
    state_next.panel_zone = 1'b0;

    // Read data is latched in setup so it is stable in access; a strobe
    // landing at that same edge shows up only in the next read
    if (setup_read) begin
      state_next.rdata = read_word;
    end

    // Panel write fires a one-cycle hub and zone load next cycle, each only if its panel bit is set
    if (access_phase && pwrite && paddr == RTC_OFS_PANEL) begin
      state_next.panel_val = pwdata[RTC_BUS_W-1:0];
      state_next.panel_hub = pwdata[RTC_PANEL_HUB_BIT];
      state_next.panel_zone = pwdata[RTC_PANEL_ZONE_BIT];
    end

    // Hub takes the low lines, zone the high lines
    if (hub_load) begin
      state_next.hub = src_bus_out[RTC_DIGIT_W-1:0];
    end
    if (zone_load) begin
      state_next.zone = src_bus_out[RTC_ZONE_LSB +: RTC_ZONE_W];
    end

    // Position-qualified address loads
    if (strobe.load_addr_one) begin
      state_next.addr_one = put_digit(state_reg.addr_one, char_pos,
                                      state_reg.hub);
    end
    if (strobe.preset_second_addr_disc) begin
      state_next.addr_two = put_digit(state_reg.addr_two, char_pos,
                                      RTC_DISC_PRESET);
    end else if (strobe.load_addr_two) begin
      state_next.addr_two = put_digit(state_reg.addr_two, char_pos,
                                      state_reg.hub);
    end
    if (strobe.load_prog_addr) begin
      state_next.prog = put_digit(state_reg.prog, char_pos,
                                  state_reg.hub);
    end

    // Condition flags, one per position
    if (strobe.load_condition_flags) begin
      unique case (char_pos)
        RTC_POS_ZERO: begin
          state_next.flag_zero = zone_upper;
        end
        RTC_POS_MINUS: begin
          state_next.flag_minus = zone_upper;
        end
        RTC_POS_CARRY: begin
          state_next.flag_carry = zone_upper;
        end
        RTC_POS_NONE: begin
          state_next.flag_zero = state_reg.flag_zero;
        end
      endcase
    end

    // Extension flops copy both zone bits
    if (strobe.load_extension) begin
      state_next.ext_one = state_reg.zone[RTC_ZONE_LOW];
      state_next.ext_two = zone_upper;
    end

    // Function and index bits arrive one per position in fetch
    if (strobe.load_function) begin
      state_next.func[char_pos] = zone_upper;
    end
    if (strobe.load_index) begin
      if (char_pos[0]) begin
        state_next.idx_b = zone_upper;
      end else begin
        state_next.idx_a = zone_upper;
      end
    end

    // Plain hub copies
    if (strobe.load_data) begin
      state_next.data = state_reg.hub;
    end
    if (strobe.load_hold) begin
      state_next.hold = state_reg.hub;
    end
    if (strobe.load_aux_one) begin
      state_next.aux_one = state_reg.hub;
    end
    if (strobe.load_length_two) begin
      state_next.len_two = state_reg.hub;
    end

    // Load beats counting; opposite events in one cycle cancel
    if (strobe.load_aux_two) begin
      state_next.aux_two = state_reg.hub;
    end else if (dec_two_evt && !inc_two_evt) begin
      state_next.aux_two = count_step(state_reg.aux_two, 1'b0);
    end else if (inc_two_evt && !dec_two_evt) begin
      state_next.aux_two = count_step(state_reg.aux_two, 1'b1);
    end
    if (strobe.load_length_one) begin
      state_next.len_one = state_reg.hub;
    end else if (dec_len_evt) begin
      state_next.len_one = count_step(state_reg.len_one, 1'b0);
    end
  end

  // Single register stage for all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule // rtc_core

// ===== core/rtc_pkg.sv
package rtc_pkg;

  // Field widths
  localparam int RTC_DIGIT_W = 4;
  localparam int RTC_ZONE_W = 2;
  localparam int RTC_BUS_W = 6;
  localparam int RTC_ADDR_W = 16;
  localparam int RTC_POS_W = 2;
  localparam int RTC_PADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] RTC_OFS_PANEL = 8'h00;
  localparam logic [7:0] RTC_OFS_HUBZONE = 8'h04;
  localparam logic [7:0] RTC_OFS_ADDR = 8'h08;
  localparam logic [7:0] RTC_OFS_PROG = 8'h0C;
  localparam logic [7:0] RTC_OFS_COUNT = 8'h10;
  localparam logic [7:0] RTC_OFS_FLAGS = 8'h14;

  // Panel register fields
  localparam int RTC_PANEL_HUB_BIT = 8;
  localparam int RTC_PANEL_ZONE_BIT = 9;

  // Count word digit positions
  localparam int RTC_CNT_DATA = 0;
  localparam int RTC_CNT_HOLD = 4;
  localparam int RTC_CNT_AUX_ONE = 8;
  localparam int RTC_CNT_AUX_TWO = 12;
  localparam int RTC_CNT_LEN_ONE = 16;
  localparam int RTC_CNT_LEN_TWO = 20;

  // Flag word bit positions
  localparam int RTC_FLG_ZERO = 0;
  localparam int RTC_FLG_MINUS = 1;
  localparam int RTC_FLG_CARRY = 2;
  localparam int RTC_FLG_EXT_ONE = 3;
  localparam int RTC_FLG_EXT_TWO = 4;
  localparam int RTC_FLG_IDX_A = 5;
  localparam int RTC_FLG_IDX_B = 6;
  localparam int RTC_FLG_FUNC = 7;

  // Source bus and zone bit positions
  localparam int RTC_ZONE_LSB = 4;
  localparam int RTC_ZONE_LOW = 0;
  localparam int RTC_ZONE_HIGH = 1;

  // Counter bits of special meaning
  localparam int RTC_RW_BIT = 0;
  localparam int RTC_NONFILL_BIT = 3;

  // Preset digit for the second operand address in disc work
  localparam logic [3:0] RTC_DISC_PRESET = 4'h4;

  // Length counter decode values
  localparam logic [3:0] RTC_LEN_ZERO = 4'h0;
  localparam logic [3:0] RTC_LEN_ONE = 4'h1;
  localparam logic [3:0] RTC_LEN_SIX = 4'h6;
  localparam logic [3:0] RTC_LEN_SEVEN = 4'h7;
  localparam logic [3:0] RTC_STEP = 4'h1;

  // Condition flag positions selected by the position counter
  localparam logic [1:0] RTC_POS_ZERO = 2'h0;
  localparam logic [1:0] RTC_POS_MINUS = 2'h1;
  localparam logic [1:0] RTC_POS_CARRY = 2'h2;
  localparam logic [1:0] RTC_POS_NONE = 2'h3;

  // Transfer and load strobes from the control sequencer
  typedef struct packed {
    logic aux_one_to_bus;
    logic aux_two_to_bus;
    logic load_hub;
    logic load_zone;
    logic load_addr_one;
    logic load_addr_two;
    logic preset_second_addr_disc;
    logic load_condition_flags;
    logic load_extension;
    logic load_function;
    logic load_index;
    logic load_data;
    logic load_hold;
    logic load_aux_one;
    logic load_aux_two;
    logic load_length_one;
    logic load_length_two;
    logic load_prog_addr;
    logic aux_two_decrement;
    logic aux_two_increment;
    logic length_one_decrement;
    logic terminate_read;
  } rtc_strobe_t;

  // Decoded indications to the sequencer
  typedef struct packed {
    logic length_one_is_zero;
    logic length_one_is_one;
    logic length_one_is_six;
    logic length_one_is_seven;
    logic aux_one_low_bit;
    logic aux_two_low_bit;
    logic nonfill_read_terminate;
  } rtc_decode_t;

endpackage : rtc_pkg

// ===== tb/rtc_props.sv
module rtc_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic [rtc_pkg::RTC_PADDR_W-1:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire rtc_pkg::rtc_strobe_t strobe, // Sequencer strobes
  input wire logic [rtc_pkg::RTC_BUS_W-1:0] src_bus_in, // Bus sources
  input wire logic [rtc_pkg::RTC_POS_W-1:0] char_pos, // Position
  input wire logic [rtc_pkg::RTC_BUS_W-1:0] src_bus_out, // Resolved bus
  input wire rtc_pkg::rtc_decode_t decode // Count decodes
);
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decrement held, then dropped with no competing load
  sequence s_len_fall;
    strobe.length_one_decrement ##1
      (!strobe.length_one_decrement && !strobe.load_length_one);
  endsequence
  property p_len_one_zero;
    s_len_fall ##0 decode.length_one_is_one |=> decode.length_one_is_zero;
  endproperty
  property p_len_seven_six;
    s_len_fall ##0 decode.length_one_is_seven |=> decode.length_one_is_six;
  endproperty
  property p_len_decode;
    $onehot0({decode.length_one_is_zero, decode.length_one_is_one,
      decode.length_one_is_six, decode.length_one_is_seven});
  endproperty
  // Gated counter's low bit must appear on the bus; zone lines clear is checked for the first counter only
  property p_gate_one;
    strobe.aux_one_to_bus |-> src_bus_out[0] == decode.aux_one_low_bit
      && src_bus_out[5:4] == 2'h0;
  endproperty
  property p_gate_two;
    strobe.aux_two_to_bus && !strobe.aux_one_to_bus
      |-> src_bus_out[0] == decode.aux_two_low_bit;
  endproperty
  // A lone count edge flips the low bit one cycle later
  property p_inc_two;
    $fell(strobe.aux_two_increment) && !$fell(strobe.aux_two_decrement)
      && !strobe.load_aux_two |=> $changed(decode.aux_two_low_bit);
  endproperty
  property p_dec_two;
    $fell(strobe.aux_two_decrement) && !$fell(strobe.aux_two_increment)
      && !strobe.load_aux_two |=> $changed(decode.aux_two_low_bit);
  endproperty
  property p_nonfill;
    decode.nonfill_read_terminate |-> strobe.terminate_read;
  endproperty
  a_len_one_zero: assert property (p_len_one_zero)
    else $error("length count one did not reach zero");
  a_len_seven_six: assert property (p_len_seven_six)
    else $error("length count seven did not reach six");
  a_len_decode: assert property (p_len_decode)
    else $error("length decodes overlap");
  a_gate_one: assert property (p_gate_one)
    else $error("first counter not on bus");
  a_gate_two: assert property (p_gate_two)
    else $error("second counter not on bus");
  a_inc_two: assert property (p_inc_two)
    else $error("increment had no effect");
  a_dec_two: assert property (p_dec_two)
    else $error("decrement had no effect");
  a_nonfill: assert property (p_nonfill)
    else $error("read terminate without request");
endmodule // rtc_props

bind rtc_core rtc_props u_props (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .strobe(strobe), .src_bus_in(src_bus_in), .char_pos(char_pos),
  .src_bus_out(src_bus_out), .decode(decode));

// ===== tb/rtc_seq_model.sv
module rtc_seq_model (
  input wire logic pclk, // Clock
  output rtc_pkg::rtc_strobe_t strobe, // Strobes to the block
  output logic [rtc_pkg::RTC_BUS_W-1:0] src_bus_in, // Bus sources
  output logic [rtc_pkg::RTC_POS_W-1:0] char_pos // Position counter
);
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  // Quiet sequencer until told otherwise
  initial begin
    strobe = '0;
    src_bus_in = 6'h3F;
    char_pos = 2'h0;
  end
  // Hold a strobe set n cycles, then drop it so trailing edges occur
  task automatic go(input rtc_strobe_t s, input logic [5:0] b,
    input logic [1:0] p, input int n);
    @(posedge pclk);
    strobe <= s;
    src_bus_in <= b;
    char_pos <= p;
    repeat (n) @(posedge pclk);
    strobe <= '0;
    src_bus_in <= ~b; // Released sources no longer show the old code
  endtask
endmodule // rtc_seq_model

// ===== tb/rtc_core_tb.sv
module rtc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, e;
  rtc_strobe_t strobe;
  logic [5:0] src_bus_in, src_bus_out;
  logic [1:0] char_pos;
  rtc_decode_t decode;
  int err_total = 0, checks = 0;
  // 25 MHz clock
  always #20 pclk = ~pclk;
  rtc_seq_model seq (.pclk(pclk), .strobe(strobe),
    .src_bus_in(src_bus_in), .char_pos(char_pos));
  rtc_core DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .strobe(strobe),
    .src_bus_in(src_bus_in), .char_pos(char_pos),
    .src_bus_out(src_bus_out), .decode(decode));
  task automatic close_out;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits on pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      close_out();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // Length decodes {zero, one, six, seven} once the count edge landed
  task automatic lchk(input logic [3:0] exp);
    repeat (2) @(negedge pclk);
    chk(32'(decode[6:3]), 32'(exp));
  endtask
  // Bus gate: look at the resolved bus while the gate is up
  task automatic gate(input rtc_strobe_t s, input logic [31:0] exp);
    fork
      seq.go(s, 6'h15, 2'h0, 1);
      begin
        @(posedge pclk);
        @(negedge pclk);
        chk(32'(src_bus_out[3:0]), exp);
      end
    join
  endtask
  // Terminate request; look at the result while the request stands
  task automatic term(input logic [31:0] exp);
    fork
      seq.go('{terminate_read:1, default:0}, 6'h00, 2'h0, 2);
      begin
        @(posedge pclk);
        @(negedge pclk);
        chk(32'(decode.nonfill_read_terminate), exp);
      end
    join
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    seq.go('{load_hub:1, load_zone:1, default:0}, 6'h2B, 2'h0, 1);
    rd(RTC_OFS_HUBZONE, 32'h2B);
    seq.go('{load_data:1, load_hold:1, load_aux_one:1, load_aux_two:1,
      load_length_one:1, load_length_two:1, default:0}, 6'h00, 2'h0, 1);
    rd(RTC_OFS_COUNT, 32'hBBBBBB);
    chk(32'(decode.aux_one_low_bit), 32'h1);
    chk(32'(decode.aux_two_low_bit), 32'h1);
    term(32'h1);
    for (int p = 0; p < 4; p++) begin
      seq.go('{load_hub:1, load_zone:1, default:0}, {2'b10, 4'(p + 1)},
        2'(p), 1);
      seq.go('{load_addr_one:1, load_addr_two:1, load_prog_addr:1,
        default:0}, 6'h00, 2'(p), 1);
    end
    rd(RTC_OFS_ADDR, 32'h43214321);
    rd(RTC_OFS_PROG, 32'h4321);
    seq.go('{load_hub:1, default:0}, 6'h09, 2'h0, 1);
    seq.go('{preset_second_addr_disc:1, load_addr_two:1, default:0},
      6'h00, 2'h2, 1);
    rd(RTC_OFS_ADDR, 32'h44214321);
    seq.go('{load_condition_flags:1, default:0}, 6'h00, 2'h0, 1);
    seq.go('{load_condition_flags:1, default:0}, 6'h00, 2'h2, 1);
    seq.go('{load_extension:1, default:0}, 6'h00, 2'h0, 1);
    seq.go('{load_function:1, default:0}, 6'h00, 2'h1, 1);
    seq.go('{load_function:1, default:0}, 6'h00, 2'h3, 1);
    seq.go('{load_index:1, default:0}, 6'h00, 2'h1, 1);
    rd(RTC_OFS_FLAGS, 32'h555);
    seq.go('{aux_two_increment:1, default:0}, 6'h00, 2'h0, 1);
    seq.go('{aux_two_decrement:1, default:0}, 6'h00, 2'h0, 2);
    seq.go('{aux_two_decrement:1, default:0}, 6'h00, 2'h0, 1);
    seq.go('{length_one_decrement:1, default:0}, 6'h00, 2'h0, 1);
    seq.go('{load_hub:1, default:0}, 6'h07, 2'h0, 1);
    seq.go('{load_length_one:1, default:0}, 6'h00, 2'h0, 1);
    lchk(4'b0001);
    seq.go('{length_one_decrement:1, default:0}, 6'h00, 2'h0, 1);
    lchk(4'b0010);
    seq.go('{load_hub:1, default:0}, 6'h01, 2'h0, 1);
    seq.go('{load_length_one:1, default:0}, 6'h00, 2'h0, 1);
    lchk(4'b0100);
    seq.go('{length_one_decrement:1, default:0}, 6'h00, 2'h0, 1);
    lchk(4'b1000);
    rd(RTC_OFS_COUNT, 32'h00B0ABBB);
    chk(32'(decode.aux_two_low_bit), 32'h0);
    chk(32'(decode.aux_one_low_bit), 32'h1);
    gate('{aux_one_to_bus:1, default:0}, 32'hB);
    rd(RTC_OFS_HUBZONE, 32'h2B);
    gate('{aux_two_to_bus:1, default:0}, 32'hA);
    rd(RTC_OFS_HUBZONE, 32'h2A);
    // Test panel path, read-only write and an unmapped place
    apb(1'b1, RTC_OFS_PANEL, 32'h325);
    rd(RTC_OFS_PANEL, 32'h25);
    rd(RTC_OFS_HUBZONE, 32'h25);
    apb(1'b1, RTC_OFS_HUBZONE, 32'h0);
    rd(RTC_OFS_HUBZONE, 32'h25);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    seq.go('{load_aux_one:1, default:0}, 6'h00, 2'h0, 1);
    term(32'h0);
    close_out();
  end
endmodule // rtc_core_tb
